// ==== include/pmu_params.svh ====
// Constants of the host control interface of the power management unit.
// Assumes a 200 MHz system clock and an external pull-up on the data line.
//
// Operation
// - Assert processor reset on power-on and button.
// - Hold processor reset at least fifty milliseconds.
// - Low reset button resets the whole unit; here rail enables and fault outputs keep following their inputs.
// - Supply fault only from enabled supplies below limit.
// - Battery fault when battery removed or discharged.
// - Low rail enable drives regulators 1,2,7, core buck.
// - High rail enable drives remaining regulators, memory buck.
// - Always-on regulator has no enable.
// - Data line changes only while clock low.
// - START falls, STOP rises, data with clock high.
// - Bus busy from START until STOP.
// - Repeated START restarts address reception.
// - Bytes are eight bits, most significant first.
// - No limit on bytes per transfer.
// - Receiver pulls data low on ninth pulse.
// - Addressed target acknowledges every received byte.
// - First byte is address 46h plus direction.
// - Direction zero writes, one reads.
// - Second byte selects register, third is stored.
`ifndef PMU_PARAMS_SVH
`define PMU_PARAMS_SVH

`define PMU_CLK_PERIOD_NS 5
`define PMU_RST_HOLD_NS   50000000
`define PMU_RST_HOLD_CYC  ((`PMU_RST_HOLD_NS + `PMU_CLK_PERIOD_NS - 1) / `PMU_CLK_PERIOD_NS)
`define PMU_TARGET_ADDR   7'h46
`define PMU_REG_COUNT     16
`define PMU_NUM_RAILS     10
`define PMU_NUM_SUPPLIES  13
`define PMU_LOW_RAIL_MASK 10'h043
`define PMU_BYTE_BITS     4'h8

`endif

// ==== include/pmu_pkg.sv ====
// Types shared by the host control interface of the power management unit.
// Assumes nothing beyond the constants header.
package pmu_pkg;

  typedef logic [7:0] pmu_byte_type;

  typedef enum logic [2:0] {
    PMU_ST_IDLE,
    PMU_ST_RX,
    PMU_ST_ACK,
    PMU_ST_TX,
    PMU_ST_TXACK
  } pmu_state_type;

endpackage

// ==== include/pmu_rst_if.sv ====
// Carrier between the unit and its processor reset timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pmu_rst_if;
  logic hold;
  logic reset_n;
  modport timer (input hold, output reset_n);
  modport user  (output hold, input reset_n);
endinterface

// ==== verilog/pmu_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
module pmu_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset.
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  // Levels.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stage    <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end
endmodule

// ==== verilog/pmu_reset_timer.sv ====
// Processor reset stretcher.
// Assumes hold is a synchronous level from the same clock.
`timescale 1ns/1ps
`include "pmu_params.svh"
module pmu_reset_timer #(
  parameter int HOLD_CYCLES = `PMU_RST_HOLD_CYC
) (
  // Clock and reset.
  input  wire logic clock_in,
  input  wire logic rstn_in,
  // Timer side of the carrier.
  pmu_rst_if.timer  rst
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] low_run;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count       <= '0;
      rst.reset_n <= 1'h0;
    end
    else if (rst.hold)
    begin
      count       <= '0;
      rst.reset_n <= 1'h0;
    end
    else if (!rst.reset_n)
    begin
      if (count == CW'(HOLD_CYCLES - 1))
        rst.reset_n <= 1'h1;
      else
        count <= count + 1'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      low_run <= '0;
    else if (rst.reset_n)
      low_run <= '0;
    else if (low_run != '1)
      low_run <= low_run + 1'h1;
  end

  property p_hold_asserts;
    @(posedge clock_in) disable iff (!rstn_in) rst.hold |=> !rst.reset_n;
  endproperty
  a_hold_asserts: assert property (p_hold_asserts) else $error("Reset not asserted on hold.");

  property p_min_low;
    @(posedge clock_in) disable iff (!rstn_in) $rose(rst.reset_n) |-> low_run >= CW'(HOLD_CYCLES);
  endproperty
  a_min_low: assert property (p_min_low) else $error("Reset released too early.");
endmodule

// ==== verilog/pmu_host_ctrl.sv ====
// Host control interface of the power management unit: rail enables,
// fault outputs, processor reset and the serial register target.
// Assumes an external pull-up on the data pin and a master that owns clock.
`timescale 1ns/1ps
`include "pmu_params.svh"
module pmu_host_ctrl #(
  parameter int RESET_HOLD_CYCLES = `PMU_RST_HOLD_CYC,
  parameter int REG_COUNT         = `PMU_REG_COUNT
) (
  // Clock and reset.
  input  wire logic                         clock_in,
  input  wire logic                         rstn_in,
  // Rail enables and push button.
  input  wire logic                         low_voltage_rail_enable_in,
  input  wire logic                         high_voltage_rail_enable_in,
  input  wire logic                         reset_button_input_n_in,
  // Supply and battery monitors.
  input  wire logic [`PMU_NUM_SUPPLIES-1:0] supply_below_limit_in,
  input  wire logic                         battery_removed_in,
  input  wire logic                         battery_discharged_in,
  // Host serial bus.
  input  wire logic                         host_bus_clock_pin_in,
  input  wire logic                         host_bus_data_pin_in,
  output logic                              host_bus_data_pin_out,
  output logic                              host_bus_data_pin_oe_out,
  output logic                              host_bus_busy_out,
  // Rail enable outputs.
  output logic [`PMU_NUM_RAILS-1:0]         regulator_enable_out,
  output logic                              core_buck_output_enable_out,
  output logic                              memory_buck_output_enable_out,
  output logic                              always_on_regulator_enable_out,
  // Status outputs.
  output logic                              processor_reset_output_n_out,
  output logic                              supply_fault_output_n_out,
  output logic                              main_battery_fault_output_n_out,
  // Register writes.
  output logic                              register_write_strobe_out,
  output pmu_pkg::pmu_byte_type             register_write_address_out,
  output pmu_pkg::pmu_byte_type             register_write_data_out
);
  import pmu_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  localparam int                          SYNC_W     = `PMU_NUM_SUPPLIES + 7;
  localparam logic [SYNC_W-1:0]           SYNC_RESET = {{(SYNC_W - 3){1'h0}}, 3'h7};
  localparam logic [`PMU_NUM_RAILS-1:0]   LOW_RAIL   = `PMU_LOW_RAIL_MASK;
  localparam int                          IW         = $clog2(REG_COUNT);

  logic [SYNC_W-1:0]            sync_bus;
  logic                         scl_s;
  logic                         sda_s;
  logic                         button_low;
  logic                         low_en_s;
  logic                         high_en_s;
  logic [`PMU_NUM_SUPPLIES-1:0] below_s;
  logic                         bat_removed_s;
  logic                         bat_dis_s;
  logic                         scl_d;
  logic                         sda_d;
  logic                         scl_rise;
  logic                         scl_fall;
  logic                         start_det;
  logic                         stop_det;

  pmu_sync #(
    .WIDTH       (SYNC_W),
    .RESET_VALUE (SYNC_RESET)
  ) u_sync (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .async_in ({battery_discharged_in, battery_removed_in, supply_below_limit_in,
                high_voltage_rail_enable_in, low_voltage_rail_enable_in,
                reset_button_input_n_in, host_bus_data_pin_in, host_bus_clock_pin_in}),
    .sync_out (sync_bus)
  );

  assign scl_s         = sync_bus[0];
  assign sda_s         = sync_bus[1];
  assign button_low    = !sync_bus[2];
  assign low_en_s      = sync_bus[3];
  assign high_en_s     = sync_bus[4];
  assign below_s       = sync_bus[5 +: `PMU_NUM_SUPPLIES];
  assign bat_removed_s = sync_bus[SYNC_W-2];
  assign bat_dis_s     = sync_bus[SYNC_W-1];

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

  // ----------------------------------------------------------------
  // Rail enables and faults
  // ----------------------------------------------------------------
  logic [`PMU_NUM_SUPPLIES-1:0] supply_on;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      core_buck_output_enable_out   <= 1'h0;
      memory_buck_output_enable_out <= 1'h0;
    end
    else
    begin
      core_buck_output_enable_out   <= low_en_s;
      memory_buck_output_enable_out <= high_en_s;
    end
  end

  for (genvar i = 0; i < `PMU_NUM_RAILS; i++)
  begin : g_rail
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
      if (!rstn_in)
        regulator_enable_out[i] <= 1'h0;
      else
        regulator_enable_out[i] <= LOW_RAIL[i] ? low_en_s : high_en_s;
    end
  end

  assign always_on_regulator_enable_out = 1'h1;
  assign supply_on = {always_on_regulator_enable_out, memory_buck_output_enable_out,
                      core_buck_output_enable_out, regulator_enable_out};

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      supply_fault_output_n_out       <= 1'h1;
      main_battery_fault_output_n_out <= 1'h1;
    end
    else
    begin
      supply_fault_output_n_out       <= !(|(below_s & supply_on));
      main_battery_fault_output_n_out <= !(bat_removed_s || bat_dis_s);
    end
  end

  // ----------------------------------------------------------------
  // Processor reset
  // ----------------------------------------------------------------
  pmu_rst_if rst_if ();

  assign rst_if.hold = button_low;

  pmu_reset_timer #(
    .HOLD_CYCLES (RESET_HOLD_CYCLES)
  ) u_timer (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .rst      (rst_if.timer)
  );

  assign processor_reset_output_n_out = rst_if.reset_n;

  // ----------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------
  pmu_state_type state;
  logic [3:0]    bit_cnt;
  logic [1:0]    byte_idx;
  pmu_byte_type  shift_in;
  pmu_byte_type  tx_shift;
  pmu_byte_type  pointer;
  pmu_byte_type  read_byte;
  logic          read_mode;
  logic          master_ack;
  logic          sda_low;
  logic          byte_end;
  pmu_byte_type  reg_file [REG_COUNT];

  function automatic logic pmu_in_range(input pmu_byte_type index);
    return int'(index) < REG_COUNT;
  endfunction

  assign byte_end                 = state == PMU_ST_RX && scl_fall && bit_cnt == `PMU_BYTE_BITS;
  assign host_bus_data_pin_out    = 1'h0;
  assign host_bus_data_pin_oe_out = sda_low;

  always_comb
  begin
    read_byte = '0;
    if (pmu_in_range(pointer))
      read_byte = reg_file[pointer[IW-1:0]];
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      host_bus_busy_out <= 1'h0;
    else if (button_low || stop_det)
      host_bus_busy_out <= 1'h0;
    else if (start_det)
      host_bus_busy_out <= 1'h1;
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state      <= PMU_ST_IDLE;
      bit_cnt    <= '0;
      byte_idx   <= '0;
      shift_in   <= '0;
      tx_shift   <= '0;
      pointer    <= '0;
      read_mode  <= 1'h0;
      master_ack <= 1'h0;
      sda_low    <= 1'h0;
    end
    else if (button_low)
    begin
      state      <= PMU_ST_IDLE;
      bit_cnt    <= '0;
      byte_idx   <= '0;
      pointer    <= '0;
      read_mode  <= 1'h0;
      master_ack <= 1'h0;
      sda_low    <= 1'h0;
    end
    else if (start_det)
    begin
      state    <= PMU_ST_RX;
      bit_cnt  <= '0;
      byte_idx <= '0;
      sda_low  <= 1'h0;
    end
    else if (stop_det)
    begin
      state   <= PMU_ST_IDLE;
      sda_low <= 1'h0;
    end
    else
    begin
      case (state)
        PMU_ST_RX:
        begin
          if (scl_rise && bit_cnt < `PMU_BYTE_BITS)
          begin
            shift_in <= {shift_in[6:0], sda_s};
            bit_cnt  <= bit_cnt + 4'h1;
          end
          else if (byte_end)
          begin
            if (byte_idx == 2'h0 && shift_in[7:1] != `PMU_TARGET_ADDR)
              state <= PMU_ST_IDLE;
            else
            begin
              sda_low <= 1'h1;
              state   <= PMU_ST_ACK;
            end
            if (byte_idx == 2'h0)
              read_mode <= shift_in[0];
            if (byte_idx == 2'h1)
              pointer <= shift_in;
            if (byte_idx == 2'h2)
              pointer <= pointer + 8'h01;
          end
        end
        PMU_ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= '0;
            if (byte_idx != 2'h2)
              byte_idx <= byte_idx + 2'h1;
            if (read_mode)
            begin
              tx_shift <= read_byte;
              sda_low  <= !read_byte[7];
              bit_cnt  <= 4'h1;
              pointer  <= pointer + 8'h01;
              state    <= PMU_ST_TX;
            end
            else
            begin
              sda_low <= 1'h0;
              state   <= PMU_ST_RX;
            end
          end
        end
        PMU_ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == `PMU_BYTE_BITS)
            begin
              sda_low <= 1'h0;
              state   <= PMU_ST_TXACK;
            end
            else
            begin
              sda_low  <= !tx_shift[6];
              tx_shift <= {tx_shift[6:0], 1'h0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
        end
        PMU_ST_TXACK:
        begin
          if (scl_rise)
            master_ack <= !sda_s;
          else if (scl_fall)
          begin
            if (master_ack)
            begin
              tx_shift <= read_byte;
              sda_low  <= !read_byte[7];
              bit_cnt  <= 4'h1;
              pointer  <= pointer + 8'h01;
              state    <= PMU_ST_TX;
            end
            else
              state <= PMU_ST_IDLE;
          end
        end
        default:
        begin
          sda_low <= 1'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      register_write_strobe_out  <= 1'h0;
      register_write_address_out <= '0;
      register_write_data_out    <= '0;
    end
    else
    begin
      register_write_strobe_out <= byte_end && byte_idx == 2'h2 && !button_low && !start_det && !stop_det;
      if (byte_end && byte_idx == 2'h2)
      begin
        register_write_address_out <= pointer;
        register_write_data_out    <= shift_in;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int k = 0; k < REG_COUNT; k++)
        reg_file[k] <= '0;
    end
    else if (button_low)
    begin
      for (int k = 0; k < REG_COUNT; k++)
        reg_file[k] <= '0;
    end
    else if (register_write_strobe_out && pmu_in_range(register_write_address_out))
      reg_file[register_write_address_out[IW-1:0]] <= register_write_data_out;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unit_reset;
    @(posedge clock_in) disable iff (!rstn_in) button_low |=> state == PMU_ST_IDLE && !sda_low;
  endproperty
  a_unit_reset: assert property (p_unit_reset) else $error("Button did not reset unit.");

  property p_supply;
    @(posedge clock_in) disable iff (!rstn_in)
      1'h1 |=> supply_fault_output_n_out == ($past(below_s & supply_on) == '0);
  endproperty
  a_supply: assert property (p_supply) else $error("Supply fault wrong.");

  property p_battery;
    @(posedge clock_in) disable iff (!rstn_in)
      (bat_removed_s || bat_dis_s) |=> !main_battery_fault_output_n_out;
  endproperty
  a_battery: assert property (p_battery) else $error("Battery fault missing.");

  property p_rails;
    @(posedge clock_in) disable iff (!rstn_in)
      1'h1 |=> core_buck_output_enable_out == regulator_enable_out[6]
               && memory_buck_output_enable_out == regulator_enable_out[9]
               && core_buck_output_enable_out == $past(low_en_s);
  endproperty
  a_rails: assert property (p_rails) else $error("Rail enables wrong.");

  property p_always_on;
    @(posedge clock_in) disable iff (!rstn_in) always_on_regulator_enable_out;
  endproperty
  a_always_on: assert property (p_always_on) else $error("Always-on regulator off.");

  property p_stable_high;
    @(posedge clock_in) disable iff (!rstn_in || button_low) $changed(sda_low) |-> !scl_s;
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("Data changed with clock high.");

  property p_start;
    @(posedge clock_in) disable iff (!rstn_in)
      start_det && !button_low |=> state == PMU_ST_RX && bit_cnt == 4'h0 && host_bus_busy_out;
  endproperty
  a_start: assert property (p_start) else $error("START not taken.");

  property p_no_ack;
    @(posedge clock_in) disable iff (!rstn_in || button_low)
      byte_end && byte_idx == 2'h0 && shift_in[7:1] != `PMU_TARGET_ADDR && !start_det && !stop_det
      |=> state == PMU_ST_IDLE && !host_bus_data_pin_oe_out;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("Foreign address acknowledged.");

  property p_ack;
    @(posedge clock_in) disable iff (!rstn_in || button_low)
      byte_end && byte_idx != 2'h0 && !start_det && !stop_det |=> host_bus_data_pin_oe_out;
  endproperty
  a_ack: assert property (p_ack) else $error("Byte not acknowledged.");

  property p_write;
    @(posedge clock_in) disable iff (!rstn_in || button_low)
      byte_end && byte_idx == 2'h2 && !start_det && !stop_det
      |=> register_write_strobe_out && register_write_data_out == $past(shift_in);
  endproperty
  a_write: assert property (p_write) else $error("Data byte not stored.");

  property p_open_drain;
    @(posedge clock_in) disable iff (!rstn_in)
      !host_bus_data_pin_out && (!host_bus_data_pin_oe_out || state inside {PMU_ST_ACK, PMU_ST_TX});
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Data pin driven high.");
endmodule

// ==== test/pmu_bus_master.sv ====
// Serial bus master model that drives the host control target.
// Assumes a pull-up on the data wire and the bench clock as time base.
`timescale 1ns/1ps
module pmu_bus_master (
  // Time base.
  input  wire logic clock_in,
  // Bus wires.
  input  wire logic data_in,
  output logic      clock_out,
  output logic      data_low_out
);
  localparam int HALF = 16;
  // ------------------------------------------------------------
  // Bus steps.
  // ------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  initial
  begin
    clock_out = 1'b1;
    data_low_out = 1'b0;
  end
  task automatic start();
    data_low_out = 1'b0;
    wt(HALF);
    clock_out = 1'b1;
    wt(HALF);
    data_low_out = 1'b1;
    wt(HALF);
    clock_out = 1'b0;
    wt(HALF);
  endtask
  task automatic stop();
    data_low_out = 1'b1;
    wt(HALF);
    clock_out = 1'b1;
    wt(HALF);
    data_low_out = 1'b0;
    wt(HALF);
  endtask
  task automatic put_bit(input logic b);
    data_low_out = !b;
    wt(HALF);
    clock_out = 1'b1;
    wt(HALF);
    clock_out = 1'b0;
    wt(2);
  endtask
  task automatic get_bit(output logic b);
    data_low_out = 1'b0;
    wt(HALF);
    clock_out = 1'b1;
    wt(HALF / 2);
    b = data_in;
    wt(HALF / 2);
    clock_out = 1'b0;
    wt(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ack = !a;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!ack);
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the host control interface.
// Assumes the bus master model and a short processor reset hold.
`timescale 1ns/1ps
`include "pmu_params.svh"
module testbench;
  import pmu_pkg::*;
  logic        clock_in, rstn_in, lo, hi, btn_n, rm, dc, scl, m_low, dout, oe, busy;
  logic        aon, prst_n, sf_n, bf_n, stb, core, mem, ack;
  logic [12:0] below;
  logic [9:0]  rails;
  logic [7:0]  rd;
  pmu_byte_type wa, wd, la, ld;
  wire         sda = ~(m_low | oe);
  int          mismatches = 0, tests_run = 0, wr_n = 0;
  pmu_host_ctrl #(.RESET_HOLD_CYCLES(20)) u_dut (.clock_in(clock_in), .rstn_in(rstn_in),
    .low_voltage_rail_enable_in(lo), .high_voltage_rail_enable_in(hi), .reset_button_input_n_in(btn_n),
    .supply_below_limit_in(below), .battery_removed_in(rm), .battery_discharged_in(dc),
    .host_bus_clock_pin_in(scl), .host_bus_data_pin_in(sda), .host_bus_data_pin_out(dout),
    .host_bus_data_pin_oe_out(oe), .host_bus_busy_out(busy), .regulator_enable_out(rails),
    .core_buck_output_enable_out(core), .memory_buck_output_enable_out(mem),
    .always_on_regulator_enable_out(aon), .processor_reset_output_n_out(prst_n),
    .supply_fault_output_n_out(sf_n), .main_battery_fault_output_n_out(bf_n),
    .register_write_strobe_out(stb), .register_write_address_out(wa), .register_write_data_out(wd));
  pmu_bus_master u_m (.clock_in(clock_in), .data_in(sda), .clock_out(scl), .data_low_out(m_low));
  // ------------------------------------------------------------
  // Clock, write monitor and helpers.
  // ------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    if (stb === 1'b1)
    begin
      wr_n <= wr_n + 1;
      la <= wa;
      ld <= wd;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic fset(input logic [12:0] b, input logic r, input logic d, input logic [1:0] e);
    below = b;
    rm = r;
    dc = d;
    tick(6);
    chk("faults", e, {sf_n, bf_n});
  endtask
  task automatic addr_reg(input logic [7:0] r);
    u_m.start();
    u_m.wbyte(8'h8c, ack);
    chk("ack addr", 1'b1, ack);
    u_m.wbyte(r, ack);
    chk("ack reg", 1'b1, ack);
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_power();
    tick(18);
    chk("prst low", 1'b0, prst_n);
    chk("always on", 1'b1, aon);
    tick(14);
    chk("prst high", 1'b1, prst_n);
  endtask
  task automatic t_rails();
    for (int i = 0; i < 4; i++)
    begin
      {hi, lo} = i[1:0];
      tick(6);
      chk("rails", {lo, hi, 10'h043 & {10{lo}} | 10'h3bc & {10{hi}}}, {core, mem, rails});
    end
  endtask
  task automatic t_faults();
    {hi, lo} = 2'b01;
    fset(13'h0008, 1'b0, 1'b0, 2'b11);
    fset(13'h0001, 1'b0, 1'b0, 2'b01);
    fset(13'h1000, 1'b0, 1'b0, 2'b01);
    fset(13'h0000, 1'b1, 1'b0, 2'b10);
    fset(13'h0000, 1'b0, 1'b1, 2'b10);
    fset(13'h0000, 1'b0, 1'b0, 2'b11);
  endtask
  task automatic t_write();
    addr_reg(8'h02);
    chk("busy", 1'b1, busy);
    u_m.wbyte(8'h5a, ack);
    chk("ack data", 1'b1, ack);
    chk("write 1", 16'h025a, {la, ld});
    u_m.wbyte(8'ha5, ack);
    chk("ack data2", 1'b1, ack);
    chk("write 2", 16'h03a5, {la, ld});
    chk("drive level", 1'b0, dout);
    u_m.stop();
    chk("free", 1'b0, busy);
    chk("writes", 16'h0002, wr_n[15:0]);
  endtask
  task automatic t_read(input logic [7:0] r, input logic [15:0] e);
    addr_reg(r);
    u_m.start();
    u_m.wbyte(8'h8d, ack);
    chk("ack read", 1'b1, ack);
    u_m.rbyte(1'b1, rd);
    chk("read 1", e[15:8], rd);
    u_m.rbyte(1'b0, rd);
    chk("read 2", e[7:0], rd);
    u_m.stop();
  endtask
  task automatic t_wrong();
    u_m.start();
    u_m.wbyte(8'h8e, ack);
    chk("ack other", 1'b0, ack);
    u_m.wbyte(8'h02, ack);
    chk("ack after", 1'b0, ack);
    u_m.stop();
    chk("no write", 16'h0002, wr_n[15:0]);
  endtask
  task automatic t_range();
    addr_reg(8'h0f);
    u_m.wbyte(8'h3c, ack);
    u_m.wbyte(8'h77, ack);
    chk("write edge", 16'h1077, {la, ld});
    u_m.stop();
    t_read(8'h0f, 16'h3c00);
  endtask
  task automatic t_button();
    {hi, lo} = 2'b11;
    btn_n = 1'b0;
    tick(6);
    chk("btn prst", 1'b0, prst_n);
    chk("btn rails", 10'h3ff, rails);
    btn_n = 1'b1;
    tick(18);
    chk("btn hold", 1'b0, prst_n);
    tick(14);
    chk("btn done", 1'b1, prst_n);
    t_read(8'h02, 16'h0000);
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog.
  // ------------------------------------------------------------
  initial
  begin
    {rstn_in, lo, hi, rm, dc, below} = '0;
    btn_n = 1'b1;
    tick(16);
    rstn_in = 1'b1;
    t_power();
    t_rails();
    t_faults();
    t_write();
    t_read(8'h02, 16'h5aa5);
    t_wrong();
    t_range();
    t_button();
    give_verdict();
  end
  initial
  begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule
